// *** irm_pkg.sv ***
// package: group and line positions of the interrupt request map
package irm_pkg;
  // counts and widths of the request map
  localparam int unsigned GROUP_COUNT      = 64;
  localparam int unsigned LINE_COUNT       = 32;
  localparam int unsigned USED_GROUPS      = 20;
  localparam int unsigned GROUP_IDX_WIDTH  = 6;
  // group numbers of the connected modules
  localparam int unsigned GRP_CPU          = 0;
  localparam int unsigned GRP_SYSTEM       = 1;
  localparam int unsigned GRP_GPIO         = 2;
  localparam int unsigned GRP_DMA          = 3;
  localparam int unsigned GRP_FLASH        = 4;
  localparam int unsigned GRP_USART_FIRST  = 5;
  localparam int unsigned GRP_SPI_FIRST    = 9;
  localparam int unsigned GRP_TWO_WIRE     = 11;
  localparam int unsigned GRP_PWM          = 12;
  localparam int unsigned GRP_SYNC_SERIAL  = 13;
  localparam int unsigned GRP_TIMER        = 14;
  localparam int unsigned GRP_ADC          = 15;
  localparam int unsigned GRP_ETH          = 16;
  localparam int unsigned GRP_USB          = 17;
  localparam int unsigned GRP_SDRAM        = 18;
  localparam int unsigned GRP_AUDIO_DAC    = 19;
  // line positions inside the system group
  localparam int unsigned LINE_RTC         = 8;
  localparam int unsigned LINE_POWER_MGR   = 9;
  localparam int unsigned LINE_FREQ_METER  = 10;
  // source counts
  localparam int unsigned EXT_IRQ_COUNT    = 8;
  localparam int unsigned GPIO_IRQ_COUNT   = 14;
  localparam int unsigned DMA_IRQ_COUNT    = 15;
  localparam int unsigned USART_COUNT      = 4;
  localparam int unsigned SPI_COUNT        = 2;
  localparam int unsigned TIMER_CH_COUNT   = 3;
  // reset value of the line registers
  localparam logic [31:0] LINES_RESET      = 32'h0000_0000;
  // one group's line vector
  typedef logic [LINE_COUNT-1:0] irm_lines_t;
endpackage : irm_pkg

// *** irm_sync.sv ***
// three-flop synchroniser with change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module irm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  import irm_pkg::*;

  logic [WIDTH-1:0] stage1;   // first capture, read only by stage2
  logic [WIDTH-1:0] stage2;   // second stage
  logic [WIDTH-1:0] stage3;   // third stage

  // shift the inputs through three flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a bit once stages two and three agree, hold otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule : irm_sync
`default_nettype wire

// *** irm_request_map.sv ***
// top: routes module request lines into grouped interrupt controller inputs
// Overview of operation
// - up to 64 groups, chosen by index
// - each group carries at most 32 lines
// - one pending per group: shared vector, priority
// - group 0 line 0: cpu compare
// - group 1: external lines, rtc, power, frequency meter
// - group 2 gpio 0-13, group 3 dma 0-14
// - single-line modules on line 0 of groups
// - pwm on group 12 line 0
// - adc group 15, timers group 14 lines 0-2
// - usb 17, ethernet 16, sdram 18, dac 19
// source order on the flattened request vector, lowest bit first:
//   cpu compare, eight external lines, rtc, power manager, frequency meter,
//   fourteen gpio lines, fifteen dma channels, flash controller, four usarts,
//   two spis, two-wire unit, pwm, synchronous serial unit, three timer
//   channels, adc, ethernet mac, usb otg, sdram controller, audio dac.
// group usage:
//   group 0       cpu compare on line 0
//   group 1       external lines 0-7, rtc 8, power manager 9, frequency meter 10
//   group 2       gpio requests on lines 0-13
//   group 3       dma channel requests on lines 0-14
//   group 4       flash controller
//   groups 5-8    usart 0 to 3, one group each
//   groups 9-10   spi 0 and 1, one group each
//   group 11      two-wire unit
//   group 12      pwm
//   group 13      synchronous serial unit
//   group 14      timer channels on lines 0-2
//   group 15      adc
//   groups 16-19  ethernet mac, usb otg, sdram controller, audio dac
//   groups 20-63  no sources, always read as zero
// timing:
//   each source passes three flops and is accepted once the second and
//   third agree; both outputs change on the fourth edge after the edge
//   that first samples a new level.
//   group_lines follows a change of group_sel one edge later.
// limitations:
//   sources are levels; a pulse shorter than two cycles may be lost, so a
//   source keeps its own flag until its handler clears it.
//   nothing is latched here: a pending flag drops as soon as every line of
//   its group is low again.
//   priority and vector are per group; the controller cannot tell lines apart
//   until the handler reads group_lines.
`timescale 1ns/100ps
`default_nettype none
module irm_request_map (
  input  wire logic                                  ref_clk,
  input  wire logic                                  nrst,
  input  wire logic                                  cpu_compare_irq,
  input  wire logic [irm_pkg::EXT_IRQ_COUNT-1:0]     external_irq_unit,
  input  wire logic                                  rtc_irq,
  input  wire logic                                  power_manager_irq,
  input  wire logic                                  frequency_meter_irq,
  input  wire logic [irm_pkg::GPIO_IRQ_COUNT-1:0]    gpio_irq,
  input  wire logic [irm_pkg::DMA_IRQ_COUNT-1:0]     peripheral_dma_irq,
  input  wire logic                                  flash_ctrl_irq,
  input  wire logic [irm_pkg::USART_COUNT-1:0]       usart_irq,
  input  wire logic [irm_pkg::SPI_COUNT-1:0]         spi_irq,
  input  wire logic                                  two_wire_irq,
  input  wire logic                                  pwm_irq,
  input  wire logic                                  sync_serial_irq,
  input  wire logic                                  timer_channel0_irq,
  input  wire logic                                  timer_channel1_irq,
  input  wire logic                                  timer_channel2_irq,
  input  wire logic                                  adc_irq,
  input  wire logic                                  ethernet_mac_irq,
  input  wire logic                                  usb_otg_irq,
  input  wire logic                                  sdram_ctrl_irq,
  input  wire logic                                  audio_dac_irq,
  input  wire logic [irm_pkg::GROUP_IDX_WIDTH-1:0]   group_sel,
  output var  logic [irm_pkg::GROUP_COUNT-1:0]       group_pending,
  output var  logic [irm_pkg::LINE_COUNT-1:0]        group_lines
);
  import irm_pkg::*;

  // width of the flattened source vector: cpu, external lines, three system
  // lines, gpio, dma, flash, usarts, spis, three serial units, timers and the
  // five single-line high-speed modules
  localparam int unsigned SRC_COUNT = 1 + EXT_IRQ_COUNT + 3 + GPIO_IRQ_COUNT
                                    + DMA_IRQ_COUNT + 1 + USART_COUNT + SPI_COUNT
                                    + 3 + TIMER_CH_COUNT + 5;

  // internal state: reset release and the source path
  logic                 rst_meta;      // reset release, first stage
  logic                 rst_n;         // reset release, used by the design
  logic [SRC_COUNT-1:0] raw_src;       // all request inputs, flattened
  logic [SRC_COUNT-1:0] sync_src;      // synchronised request inputs
  irm_lines_t           next_map [GROUP_COUNT];  // combinational group vectors

  // true when any line of a group is raised
  // used for every group, so all groups see the same reduction
  function automatic logic any_line(input irm_lines_t lines);
    any_line = |lines;
  endfunction : any_line

  // release reset through two flops
  // assertion is immediate; release is timed to ref_clk so that no flop
  // leaves reset close to a clock edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // hold the release chain low while nrst is low
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      // shift a one through once nrst is high
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // flatten the sources in a fixed order for the synchroniser
  // the order here must match the walk in the mapping process below,
  // lowest bit first, so the index counter there starts at zero
  assign raw_src = {audio_dac_irq, sdram_ctrl_irq, usb_otg_irq, ethernet_mac_irq,
                    adc_irq, timer_channel2_irq, timer_channel1_irq,
                    timer_channel0_irq, sync_serial_irq, pwm_irq, two_wire_irq,
                    spi_irq, usart_irq, flash_ctrl_irq, peripheral_dma_irq,
                    gpio_irq, frequency_meter_irq, power_manager_irq, rtc_irq,
                    external_irq_unit, cpu_compare_irq};

  // requests come from other blocks and may be asynchronous
  // one width covers every source, so all of them see the same latency
  // and no request overtakes another on its way through
  irm_sync #(
    .WIDTH    (SRC_COUNT)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (raw_src),
    .sync_out (sync_src)
  );

  // place each synchronised source at its group and line
  // p walks the flattened vector in the same order as raw_src
  // unused groups and lines stay at zero from the first loop
  always_comb begin
    int unsigned p;
    p = 0;
    // start from an empty map
    for (int g = 0; g < GROUP_COUNT; g++) begin
      next_map[g] = '0;
    end
    // processor compare request
    next_map[GRP_CPU][0] = sync_src[p];
    p = p + 1;
    // external lines fill the low lines of the system group
    for (int i = 0; i < EXT_IRQ_COUNT; i++) begin
      next_map[GRP_SYSTEM][i] = sync_src[p + i];
    end
    p = p + EXT_IRQ_COUNT;
    // fixed lines above the external ones
    next_map[GRP_SYSTEM][LINE_RTC]        = sync_src[p];
    next_map[GRP_SYSTEM][LINE_POWER_MGR]  = sync_src[p + 1];
    next_map[GRP_SYSTEM][LINE_FREQ_METER] = sync_src[p + 2];
    p = p + 3;
    // one line per gpio request
    for (int i = 0; i < GPIO_IRQ_COUNT; i++) begin
      next_map[GRP_GPIO][i] = sync_src[p + i];
    end
    p = p + GPIO_IRQ_COUNT;
    // one line per dma channel
    for (int i = 0; i < DMA_IRQ_COUNT; i++) begin
      next_map[GRP_DMA][i] = sync_src[p + i];
    end
    p = p + DMA_IRQ_COUNT;
    // single-line modules below take line 0 of their own group
    next_map[GRP_FLASH][0] = sync_src[p];
    p = p + 1;
    // usarts on consecutive groups
    for (int i = 0; i < USART_COUNT; i++) begin
      next_map[GRP_USART_FIRST + i][0] = sync_src[p + i];
    end
    p = p + USART_COUNT;
    // spis on consecutive groups
    for (int i = 0; i < SPI_COUNT; i++) begin
      next_map[GRP_SPI_FIRST + i][0] = sync_src[p + i];
    end
    p = p + SPI_COUNT;
    // two-wire, pwm and synchronous serial units
    next_map[GRP_TWO_WIRE][0]    = sync_src[p];
    next_map[GRP_PWM][0]         = sync_src[p + 1];
    next_map[GRP_SYNC_SERIAL][0] = sync_src[p + 2];
    p = p + 3;
    // timer channels share one group, one line each
    for (int i = 0; i < TIMER_CH_COUNT; i++) begin
      next_map[GRP_TIMER][i] = sync_src[p + i];
    end
    p = p + TIMER_CH_COUNT;
    // converter and the high-speed bus modules
    next_map[GRP_ADC][0]       = sync_src[p];
    next_map[GRP_ETH][0]       = sync_src[p + 1];
    next_map[GRP_USB][0]       = sync_src[p + 2];
    next_map[GRP_SDRAM][0]     = sync_src[p + 3];
    next_map[GRP_AUDIO_DAC][0] = sync_src[p + 4];
  end

  // one pending flag per group, shared by all its lines
  // taken from the same combinational map as group_lines, so a pending
  // flag and the line levels behind it change on the same edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // nothing pending while the internal reset is held
      group_pending <= '0;
    end else begin
      for (int g = 0; g < GROUP_COUNT; g++) begin
        group_pending[g] <= any_line(next_map[g]);
      end
    end
  end

  // line levels of the selected group for the handler
  // group_sel is a same-clock input, so it is used without synchronising;
  // a new index shows on group_lines one edge later
  // groups with no sources read as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // no lines visible during reset
      group_lines <= LINES_RESET;
    end else begin
      group_lines <= next_map[group_sel];
    end
  end
endmodule : irm_request_map
`default_nettype wire

// *** irm_request_map_properties.sv ***
// checker: mapping and timing properties seen at the request map ports
`timescale 1ns/100ps
`default_nettype none
module irm_request_map_properties (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        cpu_compare_irq,
  input wire logic        flash_ctrl_irq,
  input wire logic        pwm_irq,
  input wire logic        timer_channel2_irq,
  input wire logic [5:0]  group_sel,
  input wire logic [63:0] group_pending,
  input wire logic [31:0] group_lines
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // source rises and holds through the synchroniser and the output flop
  sequence s_up(s);
    $rose(s) ##1 s[*4];
  endsequence
  // source falls and stays low through the synchroniser and the output flop
  sequence s_down(s);
    $fell(s) ##1 (!s)[*4];
  endsequence
  chk_cpu_compare_up: assert property (s_up(cpu_compare_irq) |=> group_pending[0])
    else $error("cpu compare request not pending in time");
  chk_flash_group_up: assert property (s_up(flash_ctrl_irq) |=> group_pending[4])
    else $error("flash request not pending in time");
  chk_timer_two_up: assert property (s_up(timer_channel2_irq) |=> group_pending[14])
    else $error("timer channel two request not pending in time");
  chk_pwm_group_down: assert property (s_down(pwm_irq) |=> !group_pending[12])
    else $error("pwm group still pending after release");
  chk_unused_groups: assert property (group_pending[63:20] == 44'h0)
    else $error("unused group shows pending");
  chk_pending_any_line: assert property ($stable(group_sel)
    |-> group_pending[group_sel] == (|group_lines))
    else $error("group pending differs from its line levels");
  chk_system_upper_lines: assert property ($stable(group_sel) && group_sel == 6'h01
    |-> group_lines[31:11] == 21'h0)
    else $error("system group shows an unused line");
  chk_empty_group_lines: assert property ($stable(group_sel) && group_sel >= 6'h14
    |-> group_lines == 32'h0)
    else $error("unused group shows a line");
endmodule : irm_request_map_properties
`default_nettype wire

// *** irm_ctrl_model.sv ***
// controller model: walks all group indexes and keeps the line levels read
`timescale 1ns/100ps
`default_nettype none
module irm_ctrl_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] group_lines,
  output var  logic [5:0]  group_sel
);
  logic        settle;          // second cycle of a group visit
  logic [31:0] lines_seen [64]; // last line levels read per group
  // lines follow a new index one cycle late, so read on the second cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      group_sel <= 6'h0;
      settle    <= 1'b0;
    end else begin
      settle <= ~settle;
      if (settle) begin
        lines_seen[group_sel] <= group_lines;
        group_sel             <= group_sel + 6'h1;
      end
    end
  end
endmodule : irm_ctrl_model
`default_nettype wire

// *** tb_irq_request_group_map.sv ***
// testbench: request map with a scanning controller model
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_irq_request_group_map;
  // source bit, count, group, first line, one group per bit
  typedef struct { int b; int n; int g; int l; bit s; } irm_row_t;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [58:0] src     = '0; // all request sources, lowest is cpu compare
  logic [5:0]  group_sel;
  logic [63:0] group_pending;
  logic [31:0] group_lines;
  int          num_errors = 0;
  int          tests_run  = 0;
  irm_row_t    rows [11] = '{'{0,1,0,0,0}, '{1,8,1,0,0}, '{9,3,1,8,0}, '{12,14,2,0,0},
    '{26,15,3,0,0}, '{41,1,4,0,0}, '{42,4,5,0,1}, '{46,2,9,0,1}, '{48,3,11,0,1},
    '{51,3,14,0,0}, '{54,5,15,0,1}};
  irm_request_map dut (.ref_clk(ref_clk), .nrst(nrst), .cpu_compare_irq(src[0]),
    .external_irq_unit(src[8:1]), .rtc_irq(src[9]), .power_manager_irq(src[10]),
    .frequency_meter_irq(src[11]), .gpio_irq(src[25:12]), .peripheral_dma_irq(src[40:26]),
    .flash_ctrl_irq(src[41]), .usart_irq(src[45:42]), .spi_irq(src[47:46]),
    .two_wire_irq(src[48]), .pwm_irq(src[49]), .sync_serial_irq(src[50]),
    .timer_channel0_irq(src[51]), .timer_channel1_irq(src[52]),
    .timer_channel2_irq(src[53]), .adc_irq(src[54]), .ethernet_mac_irq(src[55]),
    .usb_otg_irq(src[56]), .sdram_ctrl_irq(src[57]), .audio_dac_irq(src[58]),
    .group_sel(group_sel), .group_pending(group_pending), .group_lines(group_lines));
  irm_ctrl_model ctrl (.ref_clk(ref_clk), .nrst(nrst), .group_lines(group_lines),
    .group_sel(group_sel));
  // 100 ns period
  always #50 ref_clk = ~ref_clk;
  // waits whole cycles, ending at a falling edge
  task automatic wait_cycles(int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cycles
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // main sequence; 140 cycles cover the latency and one full model scan
  initial begin
    int g;
    int l;
    wait_cycles(8);
    nrst = 1'b1;
    wait_cycles(4);
    foreach (rows[r]) begin
      for (int k = 0; k < rows[r].n; k++) begin
        g = rows[r].g + (rows[r].s ? k : 0);
        l = rows[r].l + (rows[r].s ? 0 : k);
        src = 59'h1 << (rows[r].b + k);
        wait_cycles(140);
        `CHK(group_pending, 64'h1 << g)
        `CHK(ctrl.lines_seen[g], 32'h1 << l)
      end
      $display("test row %0d done", r);
    end
    src = '1;
    wait_cycles(140);
    `CHK(group_pending, 64'h0000_0000_000f_ffff)
    `CHK(ctrl.lines_seen[1], 32'h0000_07ff)
    `CHK(ctrl.lines_seen[3], 32'h0000_7fff)
    `CHK(ctrl.lines_seen[14], 32'h0000_0007)
    `CHK(ctrl.lines_seen[40], 32'h0)
    $display("test all sources done");
    nrst = 1'b0;
    wait_cycles(2);
    `CHK(group_pending, 64'h0)
    `CHK(group_lines, 32'h0)
    nrst = 1'b1;
    wait_cycles(140);
    `CHK(group_pending, 64'h0000_0000_000f_ffff)
    src = '0;
    wait_cycles(8);
    `CHK(group_pending, 64'h0)
    $display("test reset and release done");
    report_and_stop();
  end
  // watchdog: about twice the 8,600 cycles the tests need
  initial begin
    #2_000_000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb_irq_request_group_map
bind irm_request_map irm_request_map_properties chk (.ref_clk(ref_clk), .nrst(nrst),
  .cpu_compare_irq(cpu_compare_irq), .flash_ctrl_irq(flash_ctrl_irq), .pwm_irq(pwm_irq),
  .timer_channel2_irq(timer_channel2_irq), .group_sel(group_sel),
  .group_pending(group_pending), .group_lines(group_lines));
`default_nettype wire
